// >>> design/wpcm_pkg.sv
// Shared constants and types for the watchpoint control and match block.
package wpcm_pkg;

  // ---------------------------------------------------------------
  // Register map seen on the register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_VALUE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_HIT_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_HIT_ADDRESS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_HOST_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_HOST_WATCH8 = 8'h14;

  // ---------------------------------------------------------------
  // Watchpoint control field layout
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_KIND_LSB = 3;
  localparam int CTRL_KIND_W = 2;
  localparam int CTRL_BSEL_LSB = 5;
  localparam int CTRL_BSEL_W = 8;
  localparam int CTRL_SEC_LSB = 14;
  localparam int CTRL_SEC_W = 2;
  localparam int CTRL_LINK_IDX_LSB = 16;
  localparam int CTRL_LINK_IDX_W = 4;
  localparam int CTRL_LINK_EN_BIT = 20;
  localparam int CTRL_MASK_LSB = 24;
  localparam int CTRL_MASK_W = 5;
  localparam logic [31:0] CTRL_WRITABLE = 32'h1f1f_dff9;
  localparam logic [31:0] VALUE_WRITABLE = 32'hffff_fffc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_MIN_CODE = 5'h03;
  localparam logic [4:0] MASK_WATCH8 = 5'h07;
  localparam logic [1:0] KIND_LOAD = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;
  localparam logic [1:0] KIND_EITHER = 2'h3;
  localparam logic [1:0] SEC_BOTH = 2'h0;
  localparam logic [1:0] SEC_NONSECURE = 2'h1;
  localparam logic [1:0] SEC_SECURE = 2'h2;
  localparam logic [7:0] BSEL_ALL = 8'hff;
  localparam logic [31:0] DWORD_ALIGN = 32'hffff_fff8;
  localparam int NUM_PAIRS = 16;
  localparam int HIT_STATUS_BIT = 0;
  localparam int LINK_FAULT_BIT = 0;

  typedef enum logic [1:0] {
    WPCM_IDLE = 2'b00,
    WPCM_WR_VALUE = 2'b01,
    WPCM_WR_CONTROL = 2'b11
  } wpcm_host_state_t;

endpackage

// >>> design/wpcm_if.sv
// Interface joining the watchpoint device to its controller and access path.
`timescale 1ns/1ps
`default_nettype none
interface wpcm_if;
  // Register port.
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  // Load/store access path.
  logic acc_valid;
  logic [31:0] acc_addr;
  logic [7:0] acc_lanes;
  logic acc_load;
  logic acc_store;
  logic acc_secure;
  // Context match from the breakpoint pairs.
  logic [15:0] ctx_match;
  // Debug event back to the controller.
  logic wp_event;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata,
    input acc_valid, acc_addr, acc_lanes, acc_load, acc_store, acc_secure,
    input ctx_match,
    output wp_event
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input reg_rdata,
    output acc_valid, acc_addr, acc_lanes, acc_load, acc_store, acc_secure,
    output ctx_match,
    input wp_event
  );
endinterface
`default_nettype wire

// >>> design/wpcm_device.sv
// Watchpoint control register pair and data access match logic.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Mask field bits 28:24; zero means unmasked.
// - Codes 3..31 drop that many low bits.
// - Software sets all byte selects when masking.
// - Software zeroes masked value bits on value writes; the watch shortcut clears only bits 2:0.
// - Debugger watches 128-byte block: mask 7.
// - Link enable bit 20 requires context match.
// - Bits 19:16 pick the linked pair.
// - Software links only to context-capable pairs.
// - Byte selects gate lanes; zero never hits.
// - Access kind bits 4:3 gate loads/stores.
// - Security bits 15:14 gate secure state.
// - Value compared on 31:3 (bit 2 picks the byte select half), jointly with context.
module wpcm_device (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Controller and access path
  wpcm_if.dev link,
  // User side status
  output logic armed,
  output logic debug_event
);
  import wpcm_pkg::*;

  // ---------------------------------------------------------------
  // Match helpers
  // ---------------------------------------------------------------

  // Address bits that the mask code removes from the comparison.
  function automatic logic [31:0] masked_bits(input logic [4:0] code);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (code >= MASK_MIN_CODE) begin
      m = (32'h0000_0001 << code) - 32'h0000_0001;
    end
    return m;
  endfunction

  // Byte lanes of the double word that the byte selects enable.
  function automatic logic [7:0] lane_select(input logic [7:0] bsel, input logic word_hi);
    logic [7:0] l;
    l = bsel;
    if (word_hi) begin
      l = {bsel[3:0], 4'h0};
    end
    return l;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] control_q;
  logic [31:0] control_d;
  logic [31:0] value_q;
  logic [31:0] value_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic hit_sticky_q;
  logic hit_sticky_d;
  logic [31:0] hit_addr_q;
  logic [31:0] hit_addr_d;
  logic event_q;
  logic event_d;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic enable;
  logic [1:0] kind;
  logic [7:0] bsel;
  logic [1:0] sec;
  logic [3:0] link_idx;
  logic link_en;
  logic [4:0] mask_code;
  logic [31:0] ignore;

  assign enable = control_q[CTRL_ENABLE_BIT];
  assign kind = control_q[CTRL_KIND_LSB +: CTRL_KIND_W];
  assign bsel = control_q[CTRL_BSEL_LSB +: CTRL_BSEL_W];
  assign sec = control_q[CTRL_SEC_LSB +: CTRL_SEC_W];
  assign link_idx = control_q[CTRL_LINK_IDX_LSB +: CTRL_LINK_IDX_W];
  assign link_en = control_q[CTRL_LINK_EN_BIT];
  assign mask_code = control_q[CTRL_MASK_LSB +: CTRL_MASK_W];
  assign ignore = masked_bits(mask_code);

  // ---------------------------------------------------------------
  // Access qualification
  // ---------------------------------------------------------------
  logic addr_ok;
  logic lane_ok;
  logic kind_ok;
  logic sec_ok;
  logic ctx_ok;
  logic hit;

  // The lanes carry byte granularity, so the address test itself stops at
  // the double word; bit 2 of the value only chooses which half the four
  // low byte selects cover.
  assign addr_ok = (((link.acc_addr ^ value_q) & ~ignore & DWORD_ALIGN) == 32'h0000_0000);
  assign lane_ok = |(lane_select(bsel, value_q[2]) & link.acc_lanes);

  always_comb begin
    unique case (kind)
      KIND_LOAD: kind_ok = link.acc_load;
      KIND_STORE: kind_ok = link.acc_store;
      KIND_EITHER: kind_ok = link.acc_load | link.acc_store;
      default: kind_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (sec)
      SEC_BOTH: sec_ok = 1'b1;
      SEC_NONSECURE: sec_ok = ~link.acc_secure;
      SEC_SECURE: sec_ok = link.acc_secure;
      default: sec_ok = 1'b0;
    endcase
  end

  // A linked watchpoint only fires while its chosen pair matches too.
  assign ctx_ok = ~link_en | link.ctx_match[link_idx];

  assign hit = link.acc_valid & enable & addr_ok & lane_ok & kind_ok & sec_ok & ctx_ok;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    control_d = control_q;
    value_d = value_q;
    rdata_d = 32'h0000_0000;
    hit_sticky_d = hit_sticky_q;
    hit_addr_d = hit_addr_q;
    event_d = hit;
    if (link.reg_wr) begin
      unique case (link.reg_addr)
        ADDR_CONTROL: control_d = link.reg_wdata & CTRL_WRITABLE;
        ADDR_VALUE: value_d = link.reg_wdata & VALUE_WRITABLE;
        ADDR_HIT_STATUS: begin
          if (link.reg_wdata[HIT_STATUS_BIT]) begin
            hit_sticky_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A hit in the same cycle as the clear keeps the flag set.
    if (hit) begin
      hit_sticky_d = 1'b1;
      hit_addr_d = link.acc_addr;
    end
    if (link.reg_rd) begin
      unique case (link.reg_addr)
        ADDR_CONTROL: rdata_d = control_q & CTRL_WRITABLE;
        ADDR_VALUE: rdata_d = value_q & VALUE_WRITABLE;
        ADDR_HIT_STATUS: rdata_d = {31'h0000_0000, hit_sticky_q};
        ADDR_HIT_ADDRESS: rdata_d = hit_addr_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      control_q <= CTRL_RESET;
      value_q <= VALUE_RESET;
      rdata_q <= 32'h0000_0000;
      hit_sticky_q <= 1'b0;
      hit_addr_q <= 32'h0000_0000;
      event_q <= 1'b0;
    end else begin
      control_q <= control_d;
      value_q <= value_d;
      rdata_q <= rdata_d;
      hit_sticky_q <= hit_sticky_d;
      hit_addr_q <= hit_addr_d;
      event_q <= event_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.reg_rdata = rdata_q;
  assign link.wp_event = event_q;
  assign debug_event = event_q;
  assign armed = enable;

endmodule
`default_nettype wire

// >>> design/wpcm_host.sv
// Controller end: programs the watchpoint and drives the access path.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wpcm_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software register port
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic sw_busy,
  // Breakpoint pairs able to supply a linked context match
  input wire logic [15:0] ctx_capable,
  input wire logic [15:0] ctx_match,
  // Load/store path
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [7:0] acc_lanes,
  input wire logic acc_load,
  input wire logic acc_store,
  input wire logic acc_secure,
  // Event out
  output logic wp_event,
  // Device end
  wpcm_if.host link
);
  import wpcm_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  wpcm_host_state_t state_q;
  wpcm_host_state_t state_d;
  logic [31:0] watch_addr_q;
  logic [31:0] watch_addr_d;
  logic [4:0] mask_q;
  logic [4:0] mask_d;
  logic fault_q;
  logic fault_d;
  logic rd_local_q;
  logic rd_local_d;
  logic [7:0] addr_d;
  logic [31:0] wdata_d;
  logic wr_d;
  logic rd_d;
  logic [31:0] ctrl_w;
  logic [31:0] ignore;

  assign ignore = (mask_q >= MASK_MIN_CODE) ?
      ((32'h0000_0001 << mask_q) - 32'h0000_0001) : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    watch_addr_d = watch_addr_q;
    mask_d = mask_q;
    fault_d = fault_q;
    rd_local_d = 1'b0;
    addr_d = sw_addr;
    wdata_d = sw_wdata;
    wr_d = 1'b0;
    rd_d = 1'b0;
    ctrl_w = sw_wdata;
    // Masking needs every byte select set.
    if (sw_wdata[CTRL_MASK_LSB +: CTRL_MASK_W] != MASK_NONE) begin
      ctrl_w[CTRL_BSEL_LSB +: CTRL_BSEL_W] = BSEL_ALL;
    end
    unique case (state_q)
      WPCM_IDLE: begin
        if (sw_wr) begin
          unique case (sw_addr)
            ADDR_CONTROL: begin
              wr_d = 1'b1;
              wdata_d = ctrl_w;
              mask_d = sw_wdata[CTRL_MASK_LSB +: CTRL_MASK_W];
              // Linking to a pair without context capability is dropped.
              if (sw_wdata[CTRL_LINK_EN_BIT] &&
                  !ctx_capable[sw_wdata[CTRL_LINK_IDX_LSB +: CTRL_LINK_IDX_W]]) begin
                wdata_d[CTRL_LINK_EN_BIT] = 1'b0;
                fault_d = 1'b1;
              end
            end
            ADDR_VALUE: begin
              wr_d = 1'b1;
              wdata_d = sw_wdata & ~ignore;
            end
            ADDR_HOST_STATUS: begin
              if (sw_wdata[LINK_FAULT_BIT]) begin
                fault_d = 1'b0;
              end
            end
            ADDR_HOST_WATCH8: begin
              watch_addr_d = sw_wdata & DWORD_ALIGN;
              state_d = WPCM_WR_VALUE;
            end
            default: begin
              wr_d = 1'b1;
            end
          endcase
        end else if (sw_rd) begin
          if (sw_addr == ADDR_HOST_STATUS) begin
            rd_local_d = 1'b1;
          end else begin
            rd_d = 1'b1;
          end
        end
      end
      WPCM_WR_VALUE: begin
        wr_d = 1'b1;
        addr_d = ADDR_VALUE;
        wdata_d = watch_addr_q;
        state_d = WPCM_WR_CONTROL;
      end
      WPCM_WR_CONTROL: begin
        wr_d = 1'b1;
        addr_d = ADDR_CONTROL;
        wdata_d = 32'h0000_0000;
        wdata_d[CTRL_MASK_LSB +: CTRL_MASK_W] = MASK_WATCH8;
        wdata_d[CTRL_BSEL_LSB +: CTRL_BSEL_W] = BSEL_ALL;
        wdata_d[CTRL_KIND_LSB +: CTRL_KIND_W] = KIND_STORE;
        wdata_d[CTRL_ENABLE_BIT] = 1'b1;
        mask_d = MASK_WATCH8;
        state_d = WPCM_IDLE;
      end
      default: state_d = WPCM_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= WPCM_IDLE;
      watch_addr_q <= 32'h0000_0000;
      mask_q <= MASK_NONE;
      fault_q <= 1'b0;
      rd_local_q <= 1'b0;
      link.reg_addr <= 8'h00;
      link.reg_wdata <= 32'h0000_0000;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
    end else begin
      state_q <= state_d;
      watch_addr_q <= watch_addr_d;
      mask_q <= mask_d;
      fault_q <= fault_d;
      rd_local_q <= rd_local_d;
      link.reg_addr <= addr_d;
      link.reg_wdata <= wdata_d;
      link.reg_wr <= wr_d;
      link.reg_rd <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sw_busy = (state_q != WPCM_IDLE);
  assign sw_rdata = rd_local_q ? {31'h0000_0000, fault_q} : link.reg_rdata;
  assign link.acc_valid = acc_valid;
  assign link.acc_addr = acc_addr;
  assign link.acc_lanes = acc_lanes;
  assign link.acc_load = acc_load;
  assign link.acc_store = acc_store;
  assign link.acc_secure = acc_secure;
  assign link.ctx_match = ctx_match;
  assign wp_event = link.wp_event;

endmodule
`default_nettype wire

// >>> tb/wpcm_chk.sv
// Concurrent checks on the link between the watchpoint device and its controller.
`timescale 1ns/1ps
`default_nettype none
module wpcm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Access path, context and event
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [7:0] acc_lanes,
  input wire logic acc_load,
  input wire logic acc_store,
  input wire logic acc_secure,
  input wire logic [15:0] ctx_match,
  input wire logic wp_event
);
  import wpcm_pkg::*;
  logic [31:0] ctrl_q, ctrl_d, val_q, val_d, msk;
  logic [7:0] sel;
  logic hit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Shadow of the device registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    val_d = val_q;
    if (reg_wr && reg_addr == ADDR_CONTROL) ctrl_d = reg_wdata & CTRL_WRITABLE;
    if (reg_wr && reg_addr == ADDR_VALUE) val_d = reg_wdata & VALUE_WRITABLE;
  end
  always_ff @(posedge clk) begin
    ctrl_q <= reset ? CTRL_RESET : ctrl_d;
    val_q <= reset ? VALUE_RESET : val_d;
  end
  // Reserved codes one and two are taken as no mask, like code zero.
  assign msk = (ctrl_q[28:24] >= MASK_MIN_CODE) ? ((32'h1 << ctrl_q[28:24]) - 32'h1) : 32'h0;
  assign sel = val_q[2] ? {ctrl_q[8:5], 4'h0} : ctrl_q[12:5];
  assign hit = acc_valid && ctrl_q[0] && (((acc_addr ^ val_q) & ~msk & DWORD_ALIGN) == 32'h0)
    && ((sel & acc_lanes) != 8'h0) && ((ctrl_q[3] && acc_load) || (ctrl_q[4] && acc_store))
    && (ctrl_q[15:14] == SEC_BOTH || (ctrl_q[15:14] == SEC_NONSECURE && !acc_secure)
    || (ctrl_q[15:14] == SEC_SECURE && acc_secure)) && (!ctrl_q[20] || ctx_match[ctrl_q[19:16]]);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_event_on_hit: assert property (hit |=> wp_event)
    else $error("no event after a matching access");
  a_miss_silent: assert property (!hit |=> !wp_event)
    else $error("event without a matching access");
  a_unmasked_exact: assert property (acc_valid && ctrl_q[28:24] == MASK_NONE
    && ((acc_addr ^ val_q) & DWORD_ALIGN) != 32'h0 |=> !wp_event)
    else $error("unmasked watchpoint hit on another double word");
  a_zero_bytes: assert property (acc_valid && ctrl_q[12:5] == 8'h0 |=> !wp_event)
    else $error("hit with no byte selected");
  a_kind_gate: assert property (acc_valid && !(ctrl_q[3] && acc_load)
    && !(ctrl_q[4] && acc_store) |=> !wp_event)
    else $error("hit on an access kind not selected");
  a_sec_gate: assert property (acc_valid && ctrl_q[15:14] == SEC_SECURE
    && !acc_secure |=> !wp_event)
    else $error("secure only watchpoint hit in nonsecure state");
  a_link_gate: assert property (acc_valid && ctrl_q[20]
    && !ctx_match[ctrl_q[19:16]] |=> !wp_event)
    else $error("linked watchpoint hit without context match");
  a_ctrl_readback: assert property (reg_rd && reg_addr == ADDR_CONTROL
    |=> reg_rdata == $past(ctrl_d))
    else $error("control read differs from the writable bits written");
  c_hit: cover property (hit);
  c_link_hit: cover property (hit && ctrl_q[20]);
  c_wide_mask_hit: cover property (hit && ctrl_q[28:24] == 5'h1f);
endmodule
`default_nettype wire

// >>> tb/tb_watchpoint_control_match.sv
// Self-checking bench for the watchpoint device and its controller.
`timescale 1ns/1ps
`default_nettype none
module tb_watchpoint_control_match;
  import wpcm_pkg::*;
  logic clk, reset, sw_wr, sw_rd, acc_valid, acc_load, acc_store, acc_secure;
  logic sw_busy, wp_event, armed, debug_event;
  logic [7:0] sw_addr, acc_lanes;
  logic [15:0] ctx_capable, ctx_match;
  logic [31:0] sw_wdata, sw_rdata, acc_addr, rd, m_ctrl, m_val, a;
  int fails = 0, n_tests = 0, cycles = 0;
  int codes[10] = '{0, 1, 2, 3, 4, 5, 7, 12, 30, 31};
  wpcm_if link_if();
  wpcm_device u_wpcm_device(.clk(clk), .reset(reset), .link(link_if), .armed(armed),
    .debug_event(debug_event));
  wpcm_host u_wpcm_host(.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_busy(sw_busy),
    .ctx_capable(ctx_capable), .ctx_match(ctx_match), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_lanes(acc_lanes), .acc_load(acc_load), .acc_store(acc_store),
    .acc_secure(acc_secure), .wp_event(wp_event), .link(link_if));
  wpcm_chk u_wpcm_chk(.clk(clk), .reset(reset), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
    .reg_rdata(link_if.reg_rdata), .acc_valid(link_if.acc_valid),
    .acc_addr(link_if.acc_addr), .acc_lanes(link_if.acc_lanes), .acc_load(link_if.acc_load),
    .acc_store(link_if.acc_store), .acc_secure(link_if.acc_secure),
    .ctx_match(link_if.ctx_match), .wp_event(link_if.wp_event));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole run needs about five hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: event %b, expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mask_of(input logic [31:0] c);
    return (c[28:24] >= 3) ? ((32'h1 << c[28:24]) - 32'h1) : 32'h0;
  endfunction
  function automatic logic exp_hit(input logic [31:0] ad, input logic [7:0] ln,
                                   input logic ld, input logic st, input logic sec);
    logic [7:0] bs;
    int s;
    bs = m_val[2] ? {m_ctrl[8:5], 4'h0} : m_ctrl[12:5];
    s = m_ctrl[15:14];
    return m_ctrl[0] && (((ad ^ m_val) & ~mask_of(m_ctrl) & DWORD_ALIGN) == 0)
      && ((bs & ln) != 0) && ((m_ctrl[3] && ld) || (m_ctrl[4] && st))
      && (s == 0 || (s == 1 && !sec) || (s == 2 && sec))
      && (!m_ctrl[20] || ctx_match[m_ctrl[19:16]]);
  endfunction
  task automatic sw_write(input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    sw_addr <= ad;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    #1;
    n = 0;
    while (n < 8 && sw_busy !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Only the eight byte watch shortcut keeps the controller busy, for two cycles.
    chk32(32'(n), (ad == ADDR_HOST_WATCH8) ? 32'h2 : 32'h0);
  endtask
  task automatic sw_read(input logic [7:0] ad, input int lat);
    @(posedge clk);
    sw_addr <= ad;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    if (lat == 2) @(posedge clk);
    #1 rd = sw_rdata;
  endtask
  task automatic set_ctrl(input logic [31:0] d);
    sw_write(ADDR_CONTROL, d);
    m_ctrl = d & CTRL_WRITABLE;
    if (m_ctrl[28:24] != 0) m_ctrl[12:5] = BSEL_ALL;
    if (!ctx_capable[m_ctrl[19:16]]) m_ctrl[20] = 1'b0;
  endtask
  task automatic set_val(input logic [31:0] d);
    sw_write(ADDR_VALUE, d);
    m_val = d & VALUE_WRITABLE & ~mask_of(m_ctrl);
  endtask
  task automatic access(input logic [31:0] ad, input logic [7:0] ln, input logic ld,
                        input logic st, input logic sec, input logic [15:0] cm);
    @(posedge clk);
    acc_addr <= ad;
    acc_lanes <= ln;
    acc_load <= ld;
    acc_store <= st;
    acc_secure <= sec;
    ctx_match <= cm;
    acc_valid <= 1'b1;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
    chk1(wp_event, exp_hit(ad, ln, ld, st, sec));
    chk1(debug_event, exp_hit(ad, ln, ld, st, sec));
    chk1(armed, m_ctrl[0]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {reset, sw_wr, sw_rd, acc_valid, acc_load, acc_store, acc_secure} = 7'h40;
    {sw_addr, acc_lanes, sw_wdata, acc_addr, ctx_match} = '0;
    ctx_capable = 16'hffff;
    m_ctrl = CTRL_RESET;
    m_val = VALUE_RESET;
    void'($urandom(32'h5ee90618));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    sw_read(ADDR_CONTROL, 2);
    chk32(rd, m_ctrl);
    chk1(armed, 1'b0);
    set_ctrl(32'hffff_ffff);
    sw_write(8'h40, 32'h0);
    sw_read(ADDR_CONTROL, 2);
    chk32(rd, m_ctrl);
    sw_read(8'h40, 2);
    chk32(rd, 32'h0);
    $display("test reserved bits done");
    foreach (codes[i]) begin
      set_ctrl((32'(codes[i]) << 24) | 32'h1ff9);
      set_val($urandom);
      access(m_val | ($urandom & mask_of(m_ctrl)), 8'hff, 1'b1, 1'b0, 1'b0, 16'h0);
      a = m_val ^ (32'h1 << ((codes[i] < 3) ? 3 : codes[i]));
      access(a, 8'hff, 1'b1, 1'b0, 1'b0, 16'h0);
    end
    $display("test mask codes done");
    set_ctrl(32'h1fe1);
    set_val($urandom);
    for (int k = 0; k < 16; k++) begin
      set_ctrl(32'h1fe1 | (32'(k % 4) << 3) | (32'(k / 4) << 14));
      repeat (4) access(m_val, 8'hff, 1'($urandom), 1'($urandom), 1'($urandom), 16'h0);
    end
    $display("test kind and security done");
    for (int i = 0; i < 24; i++) begin
      set_ctrl((i < 2) ? 32'h19 : (32'h19 | (32'($urandom % 256) << 5)));
      set_val($urandom);
      access(m_val, 8'($urandom), 1'b1, 1'b0, 1'b0, 16'h0);
    end
    $display("test byte selects done");
    for (int i = 0; i < 16; i++) begin
      set_ctrl(32'h0010_1ff9 | (32'(i) << 16));
      access(m_val, 8'hff, 1'b1, 1'b1, 1'b0, 16'($urandom));
    end
    @(posedge clk);
    ctx_capable <= 16'h7fff;
    set_ctrl(32'h001f_1ff9);
    sw_read(ADDR_HOST_STATUS, 1);
    chk32(rd & 32'h1, 32'h1);
    sw_write(ADDR_HOST_STATUS, 32'h1);
    sw_read(ADDR_HOST_STATUS, 1);
    chk32(rd, 32'h0);
    access(m_val, 8'hff, 1'b1, 1'b1, 1'b0, 16'h0);
    $display("test linking done");
    a = $urandom & 32'hffff_ff80;
    sw_write(ADDR_HOST_WATCH8, a);
    m_ctrl = 32'h0700_1ff1;
    m_val = a & DWORD_ALIGN;
    sw_read(ADDR_CONTROL, 2);
    chk32(rd, m_ctrl);
    sw_read(ADDR_VALUE, 2);
    chk32(rd, m_val);
    for (int i = 0; i < 8; i++) access(a + i, 8'h1 << i, 1'b0, 1'b1, 1'b0, 16'h0);
    access(a ^ 32'h80, 8'hff, 1'b0, 1'b1, 1'b0, 16'h0);
    access(a, 8'hff, 1'b1, 1'b0, 1'b0, 16'h0);
    // The last hitting access was the top byte of the watched double word.
    sw_read(ADDR_HIT_ADDRESS, 2);
    chk32(rd, a + 32'h7);
    sw_read(ADDR_HIT_STATUS, 2);
    chk32(rd, 32'h1);
    sw_write(ADDR_HIT_STATUS, 32'h1);
    sw_read(ADDR_HIT_STATUS, 2);
    chk32(rd, 32'h0);
    $display("test eight byte watch done");
    end_of_test();
  end
endmodule
`default_nettype wire
